//--- amp_ctrl_pkg.sv
package amp_ctrl_pkg;

  // switching-rate field and multiples per code (single-speed)
  localparam int RATE_W = 3;
  localparam int MULT_W = 5;
  localparam logic [MULT_W-1:0] MULT_C0 = 5'h06;
  localparam logic [MULT_W-1:0] MULT_C1 = 5'h08;
  localparam logic [MULT_W-1:0] MULT_C2 = 5'h0A;
  localparam logic [MULT_W-1:0] MULT_C3 = 5'h0C;
  localparam logic [MULT_W-1:0] MULT_C4 = 5'h0E;
  localparam logic [MULT_W-1:0] MULT_C5 = 5'h10;
  localparam logic [MULT_W-1:0] MULT_C6 = 5'h14;
  localparam logic [MULT_W-1:0] MULT_C7 = 5'h18;

  // frame period measurement width in ref_clk cycles
  localparam int PER_W = 16;

  // over-current limit scale codes
  localparam logic [1:0] OC_SCALE_100 = 2'h0;
  localparam logic [1:0] OC_SCALE_75 = 2'h1;
  localparam logic [1:0] OC_SCALE_50 = 2'h2;
  localparam logic [1:0] OC_SCALE_25 = 2'h3;
  localparam int CUR_W = 12;

  // volume ramp: one 0.5 dB code step per eight frames
  localparam int VOL_W = 8;
  localparam logic [VOL_W-1:0] VOL_MUTE = 8'h00;
  localparam logic [2:0] RAMP_FRAMES_LAST = 3'h7;
  localparam logic [VOL_W-1:0] VOL_RESET = 8'h00;

  // analog wake-up time before the stage may switch
  localparam int CLK_PERIOD_NS = 25;
  localparam int POWERUP_TIME_NS = 10000;
  localparam int POWERUP_CYC = (POWERUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRUP_W = 10;

  // mode sequencer, one-hot
  typedef enum logic [6:0] {
    ST_SHUTDOWN = 7'b0000001,
    ST_POWERUP = 7'b0000010,
    ST_SLEEP = 7'b0000100,
    ST_ACTIVE = 7'b0001000,
    ST_RAMP_DOWN = 7'b0010000,
    ST_STOP_SW = 7'b0100000,
    ST_HIZ = 7'b1000000
  } mode_t;

endpackage

//--- pwm_rate_gen.sv
`timescale 1ns/100ps
module pwm_rate_gen
  import amp_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic frame_strobe,     // one pulse per audio frame
  input wire logic [MULT_W-1:0] mult, // ticks wanted per frame
  input wire logic run,               // stage switching enabled
  output logic pwm_tick               // one switching period start
);

  logic [PER_W-1:0] cnt_r;    // cycles since last frame
  logic [PER_W-1:0] period_r; // last measured frame period
  logic [PER_W-1:0] acc_r;    // phase accumulator
  logic [PER_W:0] sum;

  assign sum = {1'b0, acc_r} + {{(PER_W + 1 - MULT_W){1'b0}}, mult};

  ////////////////////////////////////////////////////////////////////////
  // frame period measurement
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      period_r <= '0;
    end else if (frame_strobe) begin
      period_r <= cnt_r + 16'h0001;
      cnt_r <= '0;
    end else if (cnt_r != 16'hFFFF) begin
      cnt_r <= cnt_r + 16'h0001; // saturate if frames stop
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator: exactly mult ticks per frame, realigned on every frame
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_r <= '0;
      pwm_tick <= 1'b0;
    end else if (!run) begin
      acc_r <= '0;
      pwm_tick <= 1'b0;
    end else if (frame_strobe) begin
      acc_r <= '0;      // phase lock to the frame edge
      pwm_tick <= 1'b1;
    end else if (period_r != '0 && sum >= {1'b0, period_r}) begin
      acc_r <= PER_W'(sum - {1'b0, period_r});
      pwm_tick <= 1'b1;
    end else begin
      acc_r <= sum[PER_W-1:0];
      pwm_tick <= 1'b0;
    end
  end

endmodule

//--- amp_mode_pwm_control.sv
`timescale 1ns/100ps
// Functional notes
// - switching rate is frame-locked integer multiple
// - rate select is a 3-bit field
// - codes select 6,8,10,12,14,16,20,24
// - double speed halves each multiple
// - over-current raises a latching fault
// - limit scale selects 100/75/50/25 percent
// - shutdown when pin low or bit clear
// - shutdown powers stage down, outputs hi-z
// - control interface and settings survive shutdown
// - exit needs pin high and bit set
// - sleep clear on exit starts switching
// - mute clear on exit ramps volume up
// - shutdown in playback: ramp, stop, hi-z, off
// - ramp 0.5 dB per eight frames
// - sleep stops switching, keeps faults, stays powered
// - over-current enters sleep, sets error flag
// - only shutdown toggle clears fault flags
module amp_mode_pwm_control
  import amp_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic shutdown_n,                  // shutdown pin, low = shutdown
  input wire logic shutdown_bit,                // control bit, 0 = shutdown
  input wire logic sleep_bit,
  input wire logic mute_bit,
  input wire logic [RATE_W-1:0] pwm_rate_sel,
  input wire logic double_speed,                // 88.2/96 kHz frames
  input wire logic [1:0] overcurrent_limit_scale,
  input wire logic [VOL_W-1:0] volume_setting,  // programmed level
  input wire logic frame_strobe,                // one pulse per sample frame
  input wire logic [CUR_W-1:0] load_current,    // sampled stage current
  input wire logic [CUR_W-1:0] nominal_limit,   // full-scale trip level
  input wire logic overtemp_event,
  input wire logic dc_detect_event,
  output logic analog_power_en,
  output logic stage_switch_en,
  output logic outputs_hiz,
  output logic pwm_tick,
  output logic [VOL_W-1:0] volume_level,
  output logic overcurrent_error_flag,
  output logic overtemp_error_flag,
  output logic dc_error_flag,
  output logic [6:0] mode_state
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic pin_meta_r;            // first sync stage, read by sync_r only
  logic pin_sync_r;            // synchronised shutdown pin
  logic sd_req;                // combined shutdown request
  logic sd_req_d_r;            // previous request, for entry edge
  logic fault_any;             // any latched fault present
  logic oc_trip;               // current above scaled limit
  logic [CUR_W-1:0] oc_limit;  // scaled limit
  logic [MULT_W-1:0] mult_single;
  logic [MULT_W-1:0] mult;
  mode_t state_r;
  mode_t state_nxt;
  logic [PWRUP_W-1:0] pwrup_cnt_r;
  logic [2:0] frame_cnt_r;     // frames since last ramp step
  logic [VOL_W-1:0] vol_r;
  logic [VOL_W-1:0] vol_target;
  logic ramp_step;

  ////////////////////////////////////////////////////////////////////////
  // shutdown pin synchroniser and request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= shutdown_n;
      pin_sync_r <= pin_meta_r;
    end
  end

  // either source low asks for shutdown
  assign sd_req = ~pin_sync_r | ~shutdown_bit;

  // entry edge of the request, used to clear latched faults
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sd_req_d_r <= 1'b1;
    end else begin
      sd_req_d_r <= sd_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // switching-rate multiple
  always_comb begin
    case (pwm_rate_sel)
      3'h0: mult_single = MULT_C0;
      3'h1: mult_single = MULT_C1;
      3'h2: mult_single = MULT_C2;
      3'h3: mult_single = MULT_C3;
      3'h4: mult_single = MULT_C4;
      3'h5: mult_single = MULT_C5;
      3'h6: mult_single = MULT_C6;
      default: mult_single = MULT_C7;
    endcase
  end

  // frames twice as fast need half the ticks for the same frequency
  assign mult = double_speed ? (mult_single >> 1) : mult_single;

  pwm_rate_gen u_rate (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .frame_strobe(frame_strobe),
    .mult(mult),
    .run(stage_switch_en),
    .pwm_tick(pwm_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // over-current detection
  always_comb begin
    case (overcurrent_limit_scale)
      OC_SCALE_100: oc_limit = nominal_limit;
      OC_SCALE_75: oc_limit = nominal_limit - (nominal_limit >> 2);
      OC_SCALE_50: oc_limit = nominal_limit >> 1;
      OC_SCALE_25: oc_limit = nominal_limit >> 2;
      default: oc_limit = nominal_limit;
    endcase
  end

  // only judged while the stage is switching; it carries no current otherwise
  assign oc_trip = stage_switch_en && (load_current > oc_limit);

  ////////////////////////////////////////////////////////////////////////
  // latched faults: set wins over the clearing edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      overcurrent_error_flag <= 1'b0;
      overtemp_error_flag <= 1'b0;
      dc_error_flag <= 1'b0;
    end else begin
      if (oc_trip) begin
        overcurrent_error_flag <= 1'b1;
      end else if (sd_req && !sd_req_d_r) begin
        overcurrent_error_flag <= 1'b0;
      end
      if (overtemp_event) begin
        overtemp_error_flag <= 1'b1;
      end else if (sd_req && !sd_req_d_r) begin
        overtemp_error_flag <= 1'b0;
      end
      if (dc_detect_event) begin
        dc_error_flag <= 1'b1;
      end else if (sd_req && !sd_req_d_r) begin
        dc_error_flag <= 1'b0;
      end
    end
  end

  assign fault_any = overcurrent_error_flag | overtemp_error_flag | dc_error_flag;

  ////////////////////////////////////////////////////////////////////////
  // mode sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SHUTDOWN: begin
        if (!sd_req) begin
          state_nxt = ST_POWERUP;
        end
      end
      ST_POWERUP: begin
        if (sd_req) begin
          state_nxt = ST_HIZ;
        end else if (pwrup_cnt_r == PWRUP_W'(POWERUP_CYC - 1)) begin
          // faults still latched keep the stage quiet
          state_nxt = (sleep_bit || fault_any) ? ST_SLEEP : ST_ACTIVE;
        end
      end
      ST_SLEEP: begin
        if (sd_req) begin
          state_nxt = ST_HIZ;
        end else if (!sleep_bit && !fault_any) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (sd_req) begin
          state_nxt = ST_RAMP_DOWN;
        end else if (sleep_bit || fault_any) begin
          state_nxt = ST_SLEEP; // hard mute
        end
      end
      ST_RAMP_DOWN: begin
        if (fault_any) begin
          state_nxt = ST_STOP_SW; // no ramp into a fault
        end else if (vol_r == VOL_MUTE) begin
          state_nxt = ST_STOP_SW;
        end
      end
      ST_STOP_SW: state_nxt = ST_HIZ;
      ST_HIZ: state_nxt = ST_SHUTDOWN;
      default: state_nxt = ST_SHUTDOWN;
    endcase
  end

  // state register; reset parks in shutdown
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_SHUTDOWN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // power-up wait counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwrup_cnt_r <= '0;
    end else if (state_r == ST_POWERUP) begin
      pwrup_cnt_r <= pwrup_cnt_r + 10'h001;
    end else begin
      pwrup_cnt_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode outputs, registered from the next state
  // settings are inputs held outside, so shutdown never disturbs them
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      analog_power_en <= 1'b0;
      stage_switch_en <= 1'b0;
      outputs_hiz <= 1'b1;
    end else begin
      analog_power_en <= (state_nxt != ST_SHUTDOWN);
      stage_switch_en <= (state_nxt == ST_ACTIVE) || (state_nxt == ST_RAMP_DOWN);
      outputs_hiz <= (state_nxt == ST_SHUTDOWN) || (state_nxt == ST_HIZ);
    end
  end

  assign mode_state = state_r;

  ////////////////////////////////////////////////////////////////////////
  // volume ramp
  assign vol_target = (state_r == ST_ACTIVE && !mute_bit) ? volume_setting : VOL_MUTE;
  assign ramp_step = frame_strobe && (frame_cnt_r == RAMP_FRAMES_LAST);

  // eight-frame pacing
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frame_cnt_r <= '0;
    end else if (frame_strobe) begin
      frame_cnt_r <= frame_cnt_r + 3'h1;
    end
  end

  // one 0.5 dB code per step; sleep and off drop to mute at once
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vol_r <= VOL_RESET;
    end else if (state_r != ST_ACTIVE && state_r != ST_RAMP_DOWN) begin
      vol_r <= VOL_MUTE; // hard mute while not playing
    end else if (ramp_step && vol_r < vol_target) begin
      vol_r <= vol_r + 8'h01;
    end else if (ramp_step && vol_r > vol_target) begin
      vol_r <= vol_r - 8'h01;
    end
  end

  assign volume_level = vol_r;

endmodule

//--- amp_ctrl_properties.sv
`timescale 1ns/100ps
module amp_ctrl_properties
  import amp_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic shutdown_n,
  input wire logic shutdown_bit,
  input wire logic [1:0] overcurrent_limit_scale,
  input wire logic [CUR_W-1:0] load_current,
  input wire logic [CUR_W-1:0] nominal_limit,
  input wire logic analog_power_en,
  input wire logic stage_switch_en,
  input wire logic outputs_hiz,
  input wire logic pwm_tick,
  input wire logic overcurrent_error_flag,
  input wire logic [6:0] mode_state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // exact only for limits that are multiples of four
  logic [CUR_W-1:0] trip_lvl;
  assign trip_lvl = (overcurrent_limit_scale == OC_SCALE_100) ? nominal_limit :
    (overcurrent_limit_scale == OC_SCALE_75) ? nominal_limit - (nominal_limit >> 2) :
    (overcurrent_limit_scale == OC_SCALE_50) ? nominal_limit >> 1 : nominal_limit >> 2;
  // cycles spent in power-up so far
  logic [PWRUP_W-1:0] pwr_cnt_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwr_cnt_r <= '0;
    end else if (mode_state == 7'h02) begin
      pwr_cnt_r <= pwr_cnt_r + 1'b1;
    end else begin
      pwr_cnt_r <= '0;
    end
  end
  sequence run_held_s;
    (shutdown_bit && shutdown_n) [*3];
  endsequence
  sequence stop_tail_s;
    !stage_switch_en ##1 (mode_state == 7'h40 && outputs_hiz) ##1 (mode_state == 7'h01 && !analog_power_en);
  endsequence
  shutdown_hiz_a: assert property (mode_state == 7'h01 |-> outputs_hiz && !stage_switch_en)
    else $error("stage live in shutdown");
  pin_hold_a: assert property ((!shutdown_n) [*3] ##0 (mode_state == 7'h01) |=> mode_state == 7'h01)
    else $error("left shutdown with pin low");
  // an aborted power-up leaves through the hi-z state, so only the two run states are judged
  pwrup_len_a: assert property ($fell(mode_state == 7'h02) && (mode_state == 7'h04 || mode_state == 7'h08)
    |-> pwr_cnt_r == POWERUP_CYC)
    else $error("power-up length wrong");
  oc_trip_a: assert property (stage_switch_en && load_current > trip_lvl |=> overcurrent_error_flag)
    else $error("over-current not flagged");
  oc_sleep_a: assert property ($rose(overcurrent_error_flag) && mode_state == 7'h08 |=> mode_state == 7'h04 ##1 !stage_switch_en)
    else $error("over-current did not sleep");
  oc_keep_a: assert property (run_held_s ##0 overcurrent_error_flag |=> overcurrent_error_flag)
    else $error("fault flag lost");
  sleep_stage_a: assert property ((mode_state == 7'h04) [*2] |-> !stage_switch_en && analog_power_en)
    else $error("sleep state wrong");
  stop_order_a: assert property (mode_state == 7'h20 |-> stop_tail_s)
    else $error("stop sequence out of order");
  no_tick_a: assert property ((!stage_switch_en) [*2] |-> !pwm_tick)
    else $error("tick while idle");
endmodule
bind amp_mode_pwm_control amp_ctrl_properties chk (.ref_clk, .rst_n, .shutdown_n, .shutdown_bit,
  .overcurrent_limit_scale, .load_current, .nominal_limit, .analog_power_en, .stage_switch_en,
  .outputs_hiz, .pwm_tick, .overcurrent_error_flag, .mode_state);

//--- amp_host_model.sv
`timescale 1ns/100ps
module amp_host_model (
  input wire logic ref_clk,
  output logic shutdown_n,
  output logic shutdown_bit,
  output logic sleep_bit,
  output logic mute_bit
);
  // host starts with the pin low so the amplifier wakes quiet
  initial begin
    shutdown_n = 1'b0;
    shutdown_bit = 1'b1;
    sleep_bit = 1'b0;
    mute_bit = 1'b0;
  end
  // pin and bit change just after an edge
  task automatic set_sd(input logic pin, input logic bit_v);
    @(posedge ref_clk);
    #1;
    shutdown_n = pin;
    shutdown_bit = bit_v;
  endtask
  // sleep and mute bits change just after an edge
  task automatic set_bits(input logic slp_v, input logic mute_v);
    @(posedge ref_clk);
    #1;
    sleep_bit = slp_v;
    mute_bit = mute_v;
  endtask
  // latched faults go when the bit or the pin drops; this task pulses the bit low
  task automatic clear_faults();
    set_sd(1'b1, 1'b0);
    set_sd(1'b1, 1'b1);
  endtask
endmodule

//--- amp_mode_pwm_control_bench.sv
`timescale 1ns/100ps
module amp_mode_pwm_control_bench
  import amp_ctrl_pkg::*;
;
  localparam int P = 240; // frame length in clocks
  logic ref_clk = 1'b0, rst_n = 1'b0, fs = 1'b0, ds = 1'b0, ot = 1'b0, dc = 1'b0;
  logic [2:0] rate = 3'h0;
  logic [1:0] scale = 2'h0;
  logic [11:0] load = 12'h000;
  logic [7:0] vol_set = 8'h03;
  logic sdn, sdb, slp, mt, pwr, sw, hiz, tick, oc_f, ot_f, dc_f;
  logic [7:0] vol, exp_f;
  logic [6:0] st;
  int fail_count = 0, check_count = 0, fcnt = 0, cnt;
  int mults [8] = '{6, 8, 10, 12, 14, 16, 20, 24};
  logic [11:0] lims [4] = '{12'h400, 12'h300, 12'h200, 12'h100};
  ////////////////////////////////////////
  always #12.5 ref_clk = ~ref_clk;
  // frame strobe, one clock in P
  always @(posedge ref_clk) begin
    #1;
    fs = (fcnt == P - 1);
    fcnt = fs ? 0 : fcnt + 1;
  end
  amp_host_model host (.ref_clk(ref_clk), .shutdown_n(sdn), .shutdown_bit(sdb), .sleep_bit(slp), .mute_bit(mt));
  amp_mode_pwm_control DUT (.ref_clk(ref_clk), .rst_n(rst_n), .shutdown_n(sdn), .shutdown_bit(sdb),
    .sleep_bit(slp), .mute_bit(mt), .pwm_rate_sel(rate), .double_speed(ds), .overcurrent_limit_scale(scale),
    .volume_setting(vol_set), .frame_strobe(fs), .load_current(load), .nominal_limit(12'h400),
    .overtemp_event(ot), .dc_detect_event(dc), .analog_power_en(pwr), .stage_switch_en(sw),
    .outputs_hiz(hiz), .pwm_tick(tick), .volume_level(vol), .overcurrent_error_flag(oc_f),
    .overtemp_error_flag(ot_f), .dc_error_flag(dc_f), .mode_state(st));
  ////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // bounded wait for a state; running out ends the run
  task automatic wait_st(input logic [6:0] s, input int lim);
    for (int i = 0; i < lim && st !== s; i++) step(1);
    if (st !== s) begin
      chk({1'b0, st}, {1'b0, s});
      complete_run();
    end
  endtask
  // any P clocks hold one whole frame of ticks
  task automatic ticks(input logic [7:0] exp);
    cnt = 0;
    repeat (P) begin
      step(1);
      if (tick === 1'b1) cnt++;
    end
    chk(cnt[7:0], exp);
  endtask
  ////////////////////////////////////////
  initial begin
    step(6);
    rst_n = 1'b1;
    chk({1'b0, st}, 8'h01);
    chk({7'h00, hiz}, 8'h01);
    ticks(8'h00);
    step(450);
    chk({1'b0, st}, 8'h01);
    host.set_sd(1'b1, 1'b0);
    step(450);
    chk({1'b0, st}, 8'h01);
    host.set_sd(1'b1, 1'b1);
    wait_st(7'h02, 8);
    chk({7'h00, pwr}, 8'h01);
    wait_st(7'h08, 410);
    chk({7'h00, sw}, 8'h01);
    step(8 * P);
    chk(vol, 8'h01);
    step(24 * P);
    chk(vol, vol_set);
    for (int i = 0; i < 16; i++) begin
      rate = i[2:0];
      ds = i[3];
      step(2 * P);
      ticks(8'(mults[i % 8] >> ds));
    end
    // four over-current scales, then the two other fault kinds
    for (int k = 0; k < 6; k++) begin
      scale = k[1:0];
      exp_f = (k < 4) ? 8'h04 : 8'h01 << (5 - k);
      load = (k < 4) ? lims[k] : 12'h000;
      step(4);
      chk({5'h00, oc_f, ot_f, dc_f}, 8'h00);
      load = (k < 4) ? lims[k] + 12'h001 : 12'h000;
      ot = (k == 4);
      dc = (k == 5);
      step(1);
      ot = 1'b0;
      dc = 1'b0;
      load = 12'h000;
      step(2);
      chk({5'h00, oc_f, ot_f, dc_f}, exp_f);
      chk({1'b0, st}, 8'h04);
      step(20);
      chk({5'h00, oc_f, ot_f, dc_f}, exp_f);
      host.clear_faults();
      step(2);
      chk({5'h00, oc_f, ot_f, dc_f}, 8'h00);
      wait_st(7'h08, 1200);
    end
    step(32 * P);
    chk(vol, vol_set);
    // mute ramps the volume away but the stage keeps switching
    host.set_bits(1'b0, 1'b1);
    step(32 * P);
    chk(vol, 8'h00);
    chk({7'h00, sw}, 8'h01);
    // sleep stops the stage and keeps the analog side up
    host.set_bits(1'b1, 1'b0);
    step(3);
    chk({1'b0, st}, 8'h04);
    chk({6'h00, pwr, sw}, 8'h02);
    host.set_bits(1'b0, 1'b0);
    wait_st(7'h08, 4);
    step(32 * P);
    host.set_sd(1'b0, 1'b1);
    wait_st(7'h10, 4);
    chk({7'h00, sw}, 8'h01);
    wait_st(7'h01, 9000);
    chk({pwr, sw, hiz, vol[4:0]}, 8'h20);
    complete_run();
  end
endmodule
